// ==== core/seap_top.sv ====
// Purpose: Serial command engine with page write and write protection
// Assumes: Link in mode 0; spi_sck runs only while spi_cs_n is low
// Notes:   Link logic on spi_sck, programming engine on clk_sys
// Notes on behaviour
// - Locked protect enable cannot be cleared
// - Protection matrix gates array and status writes
// - Read: opcode, 16-bit address, data out MSB-first
// - Input ignored after read address received
// - Read address increments, wraps to zero
// - Write without latch is discarded
// - Protected locations are never programmed
// - While busy only status read works
// - Programming starts on select rise right after a data byte's last bit
// - Status bit 0 shows programming in progress
// - Page write increments low five bits only
// - Page overflow wraps, overwrites earlier bytes
// - Completed programming clears write latch
// - Address decode width follows array size
// - Opcodes decoded with bit 3 ignored
// - Status layout; all ones while busy
// - Protection level selects protected quarter/half/all
// - MSB first; frames start on select fall
`timescale 1ns/1ps
module seap_top #(
    parameter int   PROG_CYCLES   = seap_pkg::PROG_CYCLES,
    parameter logic LARGE_VARIANT = 1'b0
) (
    input  wire logic clk_sys,
    input  wire logic resetn,
    input  wire logic spi_sck,
    input  wire logic spi_cs_n,
    input  wire logic spi_si,
    input  wire logic wp_n,
    output logic      spi_so,
    output logic      spi_so_oe,
    output logic      busy
);
    // ============================================================
    // Declarations
    localparam logic [10:0] VAR_MASK = LARGE_VARIANT ? seap_pkg::MASK_LARGE : seap_pkg::MASK_SMALL;

    seap_pkg::seap_link_state_type lk_state_q;
    seap_pkg::seap_prog_state_type pg_state_q;
    logic                         link_rst_n;
    logic [3:0]                   cnt_q;
    logic [15:0]                  sr_q;
    logic [7:0]                   op_byte;
    logic [7:0]                   op_q;
    logic                         op_done_q;
    logic [10:0]                  addr_q;
    logic [10:0]                  full_addr;
    logic [10:0]                  rd_addr;
    logic                         rd_en;
    logic [7:0]                   arr_rd_data;
    logic                         byte_end;
    logic                         pb_we;
    logic [7:0]                   in_byte;
    logic [31:0]                  mask_q;
    logic                         boundary_q;
    logic [7:0]                   status_write_cmd_q;
    logic [7:0]                   stat_s1_q;
    logic [7:0]                   stat_s2_q;
    logic [7:0]                   stat_byte_q;
    logic                         load_q;
    logic [7:0]                   os_q;
    logic [7:0]                   out_byte;
    logic                         link_busy;
    logic                         cs_s1_q;
    logic                         cs_s2_q;
    logic                         cs_s3_q;
    logic                         wp_s1_q;
    logic                         wp_s2_q;
    logic                         frame_end;
    logic                         cmd_ok;
    logic                         stat_wr_go;
    logic                         arr_wr_go;
    logic                         pen_q;
    logic [1:0]                   bp_q;
    logic                         wel_q;
    logic [7:0]                   status_q;
    logic [4:0]                   idx_q;
    logic [4:0]                   cp_idx_q;
    logic                         cp_valid_q;
    logic [7:0]                   pb_rd_data;
    logic [seap_pkg::PROG_CNT_W-1:0] timer_q;
    logic                         prog_done;
    logic [10:0]                  cp_addr;
    logic                         arr_we;

    // Protection level against an array address
    function automatic logic addr_protected(input logic [10:0] a, input logic [1:0] lvl);
        logic [1:0] top;
        top = LARGE_VARIANT ? a[10:9] : a[9:8];
        case (lvl)
            2'b00:   addr_protected = 1'b0;
            2'b01:   addr_protected = (top == 2'b11);
            2'b10:   addr_protected = top[1];
            default: addr_protected = 1'b1;
        endcase
    endfunction : addr_protected

    // ============================================================
    // Link domain: frame state cleared while select is high
    assign link_rst_n = resetn & ~spi_cs_n;
    assign op_byte    = {sr_q[6:0], spi_si} & seap_pkg::OP_MASK;
    assign in_byte    = {sr_q[6:0], spi_si};
    assign full_addr  = {sr_q[9:0], spi_si} & VAR_MASK;
    assign byte_end   = (cnt_q[2:0] == seap_pkg::BIT_LAST);
    assign link_busy  = stat_s2_q[seap_pkg::ST_BUSY];

    always_ff @(posedge spi_sck or negedge link_rst_n) begin
        if (!link_rst_n) begin
            lk_state_q <= seap_pkg::LK_OPCODE;
            cnt_q      <= 4'h0;
        end else begin
            case (lk_state_q)
                seap_pkg::LK_OPCODE: begin
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == seap_pkg::CNT_BYTE_END) begin
                        cnt_q <= 4'h0;
                        case (op_byte)
                            seap_pkg::OP_ARR_RD,
                            seap_pkg::OP_ARR_WR:  lk_state_q <= link_busy ? seap_pkg::LK_IGNORE
                                                                          : seap_pkg::LK_ADDR;
                            seap_pkg::OP_STAT_RD: lk_state_q <= seap_pkg::LK_DATA;
                            seap_pkg::OP_STAT_WR: lk_state_q <= link_busy ? seap_pkg::LK_IGNORE
                                                                          : seap_pkg::LK_DATA;
                            default:              lk_state_q <= seap_pkg::LK_IGNORE;
                        endcase
                    end
                end
                seap_pkg::LK_ADDR: begin
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == seap_pkg::CNT_ADDR_END) begin
                        lk_state_q <= seap_pkg::LK_DATA;
                        cnt_q      <= 4'h0;
                    end
                end
                seap_pkg::LK_DATA: begin
                    cnt_q <= byte_end ? 4'h0 : cnt_q + 4'h1;
                end
                seap_pkg::LK_IGNORE: begin
                    cnt_q <= 4'h0;
                end
                default: begin
                    lk_state_q <= seap_pkg::LK_IGNORE;
                end
            endcase
        end
    end

    // Shift in on rising edges, MSB first
    always_ff @(posedge spi_sck or negedge resetn) begin
        if (!resetn) begin
            sr_q <= 16'h0000;
        end else begin
            sr_q <= {sr_q[14:0], spi_si};
        end
    end

    // Command capture; held after select rises for the programming engine
    always_ff @(posedge spi_sck or negedge resetn) begin
        if (!resetn) begin
            op_q      <= 8'h00;
            op_done_q <= 1'b0;
        end else if (lk_state_q == seap_pkg::LK_OPCODE) begin
            op_done_q <= (cnt_q == seap_pkg::CNT_BYTE_END);
            if (cnt_q == seap_pkg::CNT_BYTE_END) begin
                op_q <= op_byte;
            end
        end
    end

    // Address counter for reads and page writes
    always_ff @(posedge spi_sck or negedge resetn) begin
        if (!resetn) begin
            addr_q <= 11'h000;
        end else if (lk_state_q == seap_pkg::LK_ADDR && cnt_q == seap_pkg::CNT_ADDR_END) begin
            addr_q <= full_addr;
        end else if (lk_state_q == seap_pkg::LK_DATA && byte_end) begin
            if (op_q == seap_pkg::OP_ARR_RD) begin
                addr_q <= (addr_q + 11'h001) & VAR_MASK;
            end else if (op_q == seap_pkg::OP_ARR_WR) begin
                addr_q[4:0] <= addr_q[4:0] + 5'h01;
            end
        end
    end

    // Array read one edge ahead of the first output bit
    assign rd_en   = (lk_state_q == seap_pkg::LK_ADDR && cnt_q == seap_pkg::CNT_ADDR_END)
                   | (lk_state_q == seap_pkg::LK_DATA && byte_end && op_q == seap_pkg::OP_ARR_RD);
    assign rd_addr = (lk_state_q == seap_pkg::LK_ADDR) ? full_addr
                                                       : ((addr_q + 11'h001) & VAR_MASK);

    // Page buffer fill; data input ignored during reads
    assign pb_we = (lk_state_q == seap_pkg::LK_DATA) && byte_end && (op_q == seap_pkg::OP_ARR_WR);

    always_ff @(posedge spi_sck or negedge resetn) begin
        if (!resetn) begin
            mask_q <= 32'h0000_0000;
        end else if (lk_state_q == seap_pkg::LK_OPCODE && cnt_q == seap_pkg::CNT_BYTE_END &&
                     op_byte == seap_pkg::OP_ARR_WR && !link_busy) begin
            mask_q <= 32'h0000_0000;
        end else if (pb_we) begin
            mask_q[addr_q[4:0]] <= 1'b1;
        end
    end

    // Set only right after a data byte's last bit
    always_ff @(posedge spi_sck or negedge resetn) begin
        if (!resetn) begin
            boundary_q <= 1'b0;
        end else begin
            boundary_q <= (lk_state_q == seap_pkg::LK_DATA) && byte_end;
        end
    end

    always_ff @(posedge spi_sck or negedge resetn) begin
        if (!resetn) begin
            status_write_cmd_q <= 8'h00;
        end else if (lk_state_q == seap_pkg::LK_DATA && byte_end && op_q == seap_pkg::OP_STAT_WR) begin
            status_write_cmd_q <= in_byte;
        end
    end

    // Status byte crossing into the link domain
    always_ff @(posedge spi_sck or negedge resetn) begin
        if (!resetn) begin
            stat_s1_q <= seap_pkg::STAT_RST;
            stat_s2_q <= seap_pkg::STAT_RST;
        end else begin
            stat_s1_q <= status_q;
            stat_s2_q <= stat_s1_q;
        end
    end

    // Output byte load points
    always_ff @(posedge spi_sck or negedge link_rst_n) begin
        if (!link_rst_n) begin
            load_q      <= 1'b0;
            stat_byte_q <= seap_pkg::STAT_RST;
        end else begin
            load_q <= rd_en && (lk_state_q == seap_pkg::LK_DATA || op_q == seap_pkg::OP_ARR_RD) && !link_busy;
            if ((lk_state_q == seap_pkg::LK_OPCODE && cnt_q == seap_pkg::CNT_BYTE_END &&
                 op_byte == seap_pkg::OP_STAT_RD) ||
                (lk_state_q == seap_pkg::LK_DATA && byte_end && op_q == seap_pkg::OP_STAT_RD)) begin
                load_q      <= 1'b1;
                stat_byte_q <= stat_s2_q;
            end
        end
    end

    // Drive out on falling edges, MSB first
    assign out_byte = (op_q == seap_pkg::OP_STAT_RD) ? stat_byte_q : arr_rd_data;

    always_ff @(negedge spi_sck or negedge link_rst_n) begin
        if (!link_rst_n) begin
            spi_so    <= 1'b0;
            spi_so_oe <= 1'b0;
            os_q      <= 8'h00;
        end else if (load_q) begin
            spi_so    <= out_byte[7];
            os_q      <= {out_byte[6:0], 1'b0};
            spi_so_oe <= 1'b1;
        end else begin
            spi_so <= os_q[7];
            os_q   <= {os_q[6:0], 1'b0};
        end
    end

    // ============================================================
    // System domain: select and protect pin synchronisers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
            wp_s1_q <= 1'b1;
            wp_s2_q <= 1'b1;
        end else begin
            cs_s1_q <= spi_cs_n;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
            wp_s1_q <= wp_n;
            wp_s2_q <= wp_s1_q;
        end
    end

    // Link results are static once select is high
    assign frame_end  = cs_s2_q & ~cs_s3_q;
    assign cmd_ok     = frame_end & op_done_q & (pg_state_q == seap_pkg::PG_IDLE);
    assign stat_wr_go = cmd_ok && op_q == seap_pkg::OP_STAT_WR && boundary_q && wel_q &&
                        (!pen_q || wp_s2_q);
    assign arr_wr_go  = cmd_ok && op_q == seap_pkg::OP_ARR_WR && boundary_q && wel_q &&
                        (mask_q != 32'h0000_0000);
    assign prog_done  = (pg_state_q == seap_pkg::PG_WAIT) &&
                        (timer_q == seap_pkg::PROG_CNT_W'(PROG_CYCLES - 1));

    // Write-enable latch
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wel_q <= 1'b0;
        end else if (cmd_ok && op_q == seap_pkg::OP_SET_WEL) begin
            wel_q <= 1'b1;
        end else if (prog_done || (cmd_ok && op_q == seap_pkg::OP_CLR_WEL)) begin
            wel_q <= 1'b0;
        end
    end

    // Protection bits
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pen_q <= seap_pkg::PEN_RST;
            bp_q  <= seap_pkg::BP_RST;
        end else if (stat_wr_go) begin
            pen_q <= status_write_cmd_q[seap_pkg::ST_PEN];
            bp_q  <= status_write_cmd_q[seap_pkg::ST_BP_HI:seap_pkg::ST_BP_LO];
        end
    end

    // Programming sequencer: copy page (array writes only; status writes skip it), then timed wait
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pg_state_q <= seap_pkg::PG_IDLE;
            idx_q      <= 5'h00;
            timer_q    <= '0;
            busy       <= 1'b0;
        end else begin
            case (pg_state_q)
                seap_pkg::PG_IDLE: begin
                    idx_q   <= 5'h00;
                    timer_q <= '0;
                    if (arr_wr_go) begin
                        pg_state_q <= seap_pkg::PG_COPY;
                        busy       <= 1'b1;
                    end else if (stat_wr_go) begin
                        pg_state_q <= seap_pkg::PG_WAIT;
                        busy       <= 1'b1;
                    end
                end
                seap_pkg::PG_COPY: begin
                    idx_q <= idx_q + 5'h01;
                    if (idx_q == seap_pkg::IDX_LAST) begin
                        pg_state_q <= seap_pkg::PG_WAIT;
                    end
                end
                seap_pkg::PG_WAIT: begin
                    timer_q <= timer_q + 1'b1;
                    if (prog_done) begin
                        pg_state_q <= seap_pkg::PG_IDLE;
                        busy       <= 1'b0;
                    end
                end
                default: begin
                    pg_state_q <= seap_pkg::PG_IDLE;
                    busy       <= 1'b0;
                end
            endcase
        end
    end

    // Page buffer read pipeline stage
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cp_valid_q <= 1'b0;
            cp_idx_q   <= 5'h00;
        end else begin
            cp_valid_q <= (pg_state_q == seap_pkg::PG_COPY);
            cp_idx_q   <= idx_q;
        end
    end

    assign cp_addr = {addr_q[10:5], cp_idx_q};
    assign arr_we  = cp_valid_q && mask_q[cp_idx_q] && !addr_protected(cp_addr, bp_q);

    // Status view, all ones while busy
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            status_q <= seap_pkg::STAT_RST;
        end else if (busy) begin
            status_q <= seap_pkg::STAT_BUSY;
        end else begin
            status_q <= {pen_q, 3'b000, bp_q, wel_q, 1'b0};
        end
    end

    // ============================================================
    // Storage
    seap_mem #(
        .W  (8),
        .AW (seap_pkg::ARRAY_AW),
        .D  (seap_pkg::ARRAY_DEPTH)
    ) u_array (
        .wr_clk  (clk_sys),
        .wr_en   (arr_we),
        .wr_addr (cp_addr),
        .wr_data (pb_rd_data),
        .rd_clk  (spi_sck),
        .rd_en   (rd_en),
        .rd_addr (rd_addr),
        .rd_data (arr_rd_data)
    );

    seap_mem #(
        .W  (8),
        .AW (seap_pkg::PAGE_AW),
        .D  (seap_pkg::PAGE_DEPTH)
    ) u_page (
        .wr_clk  (spi_sck),
        .wr_en   (pb_we),
        .wr_addr (addr_q[4:0]),
        .wr_data (in_byte),
        .rd_clk  (clk_sys),
        .rd_en   (pg_state_q == seap_pkg::PG_COPY),
        .rd_addr (idx_q),
        .rd_data (pb_rd_data)
    );
endmodule : seap_top

// ==== include/seap_pkg.sv ====
// Purpose: Shared constants for the serial EEPROM command engine
// Assumes: Mode 0 link, byte-wide array of up to 2048 bytes
// Notes:   Opcodes are compared after masking out bit 3
package seap_pkg;
    // ============================================================
    // Geometry
    localparam int         ADDR_W      = 16;
    localparam int         ARRAY_AW    = 11;
    localparam int         ARRAY_DEPTH = 2048;
    localparam int         PAGE_AW     = 5;
    localparam int         PAGE_DEPTH  = 32;
    localparam logic [10:0] MASK_SMALL = 11'h03ff;
    localparam logic [10:0] MASK_LARGE = 11'h07ff;
    // ============================================================
    // Opcodes
    localparam logic [7:0] OP_MASK    = 8'hf7;
    localparam logic [7:0] OP_SET_WEL = 8'h06;
    localparam logic [7:0] OP_CLR_WEL = 8'h04;
    localparam logic [7:0] OP_STAT_RD = 8'h05;
    localparam logic [7:0] OP_STAT_WR = 8'h01;
    localparam logic [7:0] OP_ARR_RD  = 8'h03;
    localparam logic [7:0] OP_ARR_WR  = 8'h02;
    // ============================================================
    // Status byte layout and reset values
    localparam int         ST_PEN      = 7;
    localparam int         ST_BP_HI    = 3;
    localparam int         ST_BP_LO    = 2;
    localparam int         ST_WEL      = 1;
    localparam int         ST_BUSY     = 0;
    localparam logic [7:0] STAT_BUSY   = 8'hff;
    localparam logic [7:0] STAT_RST    = 8'h00;
    localparam logic       PEN_RST     = 1'b0;
    localparam logic [1:0] BP_RST      = 2'b00;
    // ============================================================
    // Link counters and page copy index
    localparam logic [3:0] CNT_BYTE_END = 4'h7;
    localparam logic [3:0] CNT_ADDR_END = 4'hf;
    localparam logic [2:0] BIT_LAST     = 3'h7;
    localparam logic [4:0] IDX_LAST     = 5'h1f;
    // ============================================================
    // Timing
    localparam int PROG_TIME_US = 4000;
    localparam int SYS_CLK_MHZ  = 200;
    localparam int PROG_CYCLES  = PROG_TIME_US * SYS_CLK_MHZ;
    localparam int PROG_CNT_W   = 20;
    // ============================================================
    // State encodings
    typedef enum logic [1:0] {
        LK_OPCODE = 2'b00,
        LK_ADDR   = 2'b01,
        LK_DATA   = 2'b11,
        LK_IGNORE = 2'b10
    } seap_link_state_type;
    typedef enum logic [1:0] {
        PG_IDLE = 2'b00,
        PG_COPY = 2'b01,
        PG_WAIT = 2'b11
    } seap_prog_state_type;
endpackage : seap_pkg

// ==== core/seap_mem.sv ====
// Purpose: Simple two-clock memory, one write port and one read port
// Assumes: Caller never reads and writes one word in the same instant
// Notes:   Read data come out of a register on the read clock
`timescale 1ns/1ps
module seap_mem #(
    parameter int W  = 8,
    parameter int AW = 5,
    parameter int D  = 32
) (
    input  wire logic          wr_clk,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [W-1:0]  wr_data,
    input  wire logic          rd_clk,
    input  wire logic          rd_en,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [W-1:0]  rd_data
);
    logic [W-1:0] mem_q [D];

    always_ff @(posedge wr_clk) begin
        if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge rd_clk) begin
        if (rd_en) begin
            rd_data <= mem_q[rd_addr];
        end
    end
endmodule : seap_mem

// ==== tb/seap_monitor.sv ====
// Purpose: Port checks for the serial command engine
// Assumes: Mode 0 link, busy on clk_sys
// Notes:   Bound into the top from the bench
`timescale 1ns/1ps
module seap_monitor #(
    parameter int PROG_CYCLES = 50
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic spi_sck,
    input wire logic spi_cs_n,
    input wire logic spi_si,
    input wire logic wp_n,
    input wire logic spi_so,
    input wire logic spi_so_oe,
    input wire logic busy
);
    // ====
    // Busy length and frame bit counters
    int         busy_cnt_q;
    logic [4:0] rise_cnt_q;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) busy_cnt_q <= 0;
        else busy_cnt_q <= busy ? busy_cnt_q + 1 : 0;
    end
    always_ff @(posedge spi_sck or posedge spi_cs_n) begin
        if (spi_cs_n) rise_cnt_q <= 5'h00;
        else if (rise_cnt_q != 5'h1f) rise_cnt_q <= rise_cnt_q + 5'h01;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    a_oe_when_idle: assert property (spi_cs_n |-> !spi_so_oe) else $error("oe while deselected");
    a_so_when_idle: assert property (spi_cs_n |-> !spi_so) else $error("so while deselected");
    a_busy_after_deselect: assert property ($rose(busy) |-> $past(spi_cs_n)) else $error("early busy");
    a_busy_min_length: assert property ($fell(busy) |-> busy_cnt_q >= PROG_CYCLES) else $error("short");
    a_busy_max_length: assert property (busy |-> busy_cnt_q <= PROG_CYCLES + 64) else $error("long");
    a_busy_idle_gap: assert property ($fell(busy) |=> !busy [*4]) else $error("busy again");
    a_so_hold_high: assert property ((spi_sck && $past(spi_sck) && !spi_cs_n && !$past(spi_cs_n))
        |-> $stable(spi_so)) else $error("so moved while sck high");
    a_oe_after_opcode: assert property (@(posedge spi_sck) disable iff (!resetn || spi_cs_n)
        rise_cnt_q < 5'h08 |-> !spi_so_oe) else $error("oe before opcode end");
endmodule : seap_monitor

// ==== tb/seap_host.sv ====
// Purpose: Host side of the serial link
// Assumes: Mode 0, frames built from byte queues
// Notes:   Link clock runs only inside frames
`timescale 1ns/1ps
module seap_host (
    output logic      spi_sck,
    output logic      spi_cs_n,
    output logic      spi_si,
    input  wire logic spi_so
);
    logic [7:0] tx_q[$];
    logic [7:0] rx_q[$];
    int         skip = 99;
    int         hp = 16;
    initial begin
        spi_sck = 1'b0;
        spi_cs_n = 1'b1;
        spi_si = 1'b0;
    end
    task automatic run;
        logic [7:0] b;
        logic [7:0] r;
        int         n;
        n = 0;
        #3 spi_cs_n = 1'b0;
        while (tx_q.size() != 0) begin
            b = tx_q.pop_front();
            for (int i = 7; i >= 0; i--) begin
                spi_si = b[i];
                #(hp) spi_sck = 1'b1;
                r[i] = spi_so;
                #(hp) spi_sck = 1'b0;
            end
            if (n >= skip) rx_q.push_back(r);
            n++;
        end
        #(hp / 2) spi_cs_n = 1'b1;
        spi_si = ~spi_si;
        #100;
    endtask : run
endmodule : seap_host

// ==== tb/seap_top_tb.sv ====
// Purpose: Self-checking bench for the serial command engine
// Assumes: 1024-byte variant, short programming time
// Notes:   Host model drives the link
`timescale 1ns/1ps
module seap_top_tb;
    logic       clk_sys;
    logic       resetn;
    logic       wp_n;
    logic       spi_sck;
    logic       spi_cs_n;
    logic       spi_si;
    logic       spi_so;
    logic       spi_so_oe;
    logic       busy;
    logic [7:0] mem[1024];
    logic [7:0] exp_q[$];
    int         num_errors = 0;
    int         tests_run = 0;
    seap_top #(.PROG_CYCLES(800), .LARGE_VARIANT(1'b0)) i_seap_top (.clk_sys(clk_sys), .resetn(resetn),
        .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si), .wp_n(wp_n), .spi_so(spi_so),
        .spi_so_oe(spi_so_oe), .busy(busy));
    seap_host i_seap_host (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_so(spi_so));
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic chk_busy(input logic e);
        tests_run++;
        if (busy !== e) begin
            num_errors++;
            $display("Error busy expected %b seen %b", e, busy);
        end
    endtask : chk_busy
    task automatic go(input logic [7:0] b[$], input int sk);
        i_seap_host.skip = sk;
        i_seap_host.tx_q = b;
        i_seap_host.run();
    endtask : go
    task automatic stat(input logic [7:0] e);
        exp_q.push_back(e);
        go({8'h05, 8'h5a}, 1);
    endtask : stat
    task automatic page(input logic [15:0] a, input int n);
        logic [7:0] q[$];
        q = {8'h02, a[15:8], a[7:0]};
        for (int k = 0; k < n; k++) begin
            q.push_back(8'($urandom));
            mem[{a[9:5], 5'(a[4:0] + k)}] = q[k + 3];
        end
        go(q, 99);
    endtask : page
    task automatic rd(input logic [15:0] a, input int n);
        logic [7:0] q[$];
        q = {8'h03, a[15:8], a[7:0]};
        for (int k = 0; k < n; k++) begin
            exp_q.push_back(mem[10'(a + k)]);
            q.push_back(8'($urandom));
        end
        go(q, 3);
    endtask : rd
    task automatic idle;
        for (int i = 0; i < 4000 && busy !== 1'b0; i++) @(negedge clk_sys);
        chk_busy(1'b0);
    endtask : idle
    task automatic complete_run;
        if (exp_q.size() != 0) num_errors++;
        $display("Checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : complete_run
    // ====
    // Scoreboard and watchdog
    initial begin
        forever begin
            wait (i_seap_host.rx_q.size() != 0);
            chk("rx_byte", exp_q.pop_front(), i_seap_host.rx_q.pop_front());
        end
    end
    initial begin
        #400000;
        num_errors++;
        complete_run();
    end
    initial begin
        resetn = 1'b0;
        wp_n = 1'b1;
        void'($urandom(32'h4162));
        repeat (16) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (4) @(negedge clk_sys);
        stat(8'h00);
        go({8'h02, 8'h03, 8'he5, 8'h5a}, 99);
        chk_busy(1'b0);
        go({8'h0e}, 9);
        stat(8'h02);
        page(16'hfffe, 34);
        chk_busy(1'b1);
        stat(8'hff);
        exp_q.push_back(8'h00);
        go({8'h03, 8'h00, 8'h00, 8'h00}, 3);
        idle();
        stat(8'h00);
        go({8'h06}, 9);
        page(16'h0000, 1);
        idle();
        rd(16'hffe0, 33);
        go({8'h06}, 9);
        go({8'h01, 8'h8c}, 9);
        idle();
        stat(8'h8c);
        go({8'h06}, 9);
        go({8'h02, 8'h00, 8'h00, 8'h77}, 9);
        idle();
        rd(16'h0000, 1);
        @(negedge clk_sys) wp_n = 1'b0;
        go({8'h06}, 9);
        go({8'h01, 8'h00}, 9);
        idle();
        go({8'h04}, 9);
        stat(8'h8c);
        @(negedge clk_sys) wp_n = 1'b1;
        go({8'h06}, 9);
        go({8'h01, 8'h00}, 9);
        idle();
        stat(8'h00);
        complete_run();
    end
endmodule : seap_top_tb
bind seap_top seap_monitor #(.PROG_CYCLES(PROG_CYCLES)) i_seap_monitor (.clk_sys(clk_sys), .resetn(resetn),
    .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si), .wp_n(wp_n), .spi_so(spi_so),
    .spi_so_oe(spi_so_oe), .busy(busy));
